// *** verilog/dcp_clock_ctrl.sv ***
`timescale 1ns/1ns
// How it works
// - the converter clock domain (clk here) runs the core.
// - the converter clock is the input directly or, in pll mode, the loop output with the input as reference.
// - the three-bit prescaler field is the divide value in plain binary.
// - the six-bit coarse-tune field is passed to the vco to shift its centre frequency.
// - the eight-bit m field divides the converter clock to give the detector update rate.
// - the charge-pump field selects single current with 01 and double with 11.
// - in pll mode the block makes its own output_strobe from the n-divider at the detector rate.
module dcp_clock_ctrl #(
    parameter int M_WIDTH = 8
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // register bus
    input wire dcp_pkg::dcp_axi_req_s axi_req,
    output dcp_pkg::dcp_axi_rsp_s axi_rsp,
    // strobe from the pins, used in bypass mode
    input wire logic ext_output_strobe,
    // analog controls and status
    output dcp_pkg::dcp_cfg_s cfg_q,
    output logic use_pll_clock_q,
    output logic output_strobe_q,
    output logic loop_ratio_bad_q
);
    import dcp_pkg::*;

    // the register layout holds exactly eight m bits
    if (M_WIDTH != 8) begin : g_bad_width
        $error("M_WIDTH must be 8");
    end

    logic [31:0] reg_a_q;
    logic [31:0] reg_b_q;
    logic [15:0] conv_div_q;
    logic aw_seen_q, w_seen_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [7:0] m_cnt_q;
    logic [15:0] n_cnt_q;
    logic [10:0] loop_ratio;
    logic [31:0] conv_merged;
    dcp_mode_e mode;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // write address and data are captured in either order
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_seen_q <= 1'b0;
            w_seen_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            axi_rsp.awready <= 1'b0;
            axi_rsp.wready <= 1'b0;
            axi_rsp.bvalid <= 1'b0;
            axi_rsp.bresp <= DCP_RESP_OKAY;
        end else if (clk_en) begin
            axi_rsp.awready <= 1'b0;
            axi_rsp.wready <= 1'b0;
            if (axi_req.awvalid && !aw_seen_q && !axi_rsp.awready && !axi_rsp.bvalid) begin
                axi_rsp.awready <= 1'b1;
                aw_seen_q <= 1'b1;
                aw_addr_q <= axi_req.awaddr;
            end
            if (axi_req.wvalid && !w_seen_q && !axi_rsp.wready && !axi_rsp.bvalid) begin
                axi_rsp.wready <= 1'b1;
                w_seen_q <= 1'b1;
                w_data_q <= axi_req.wdata;
                w_strb_q <= axi_req.wstrb;
            end
            if (aw_seen_q && w_seen_q && !axi_rsp.bvalid) begin
                axi_rsp.bvalid <= 1'b1;
                aw_seen_q <= 1'b0;
                w_seen_q <= 1'b0;
                if (aw_addr_q == DCP_OFS_SETUP_A || aw_addr_q == DCP_OFS_SETUP_B
                    || aw_addr_q == DCP_OFS_CONV_DIV || aw_addr_q == DCP_OFS_STATUS) begin
                    axi_rsp.bresp <= DCP_RESP_OKAY;
                end else begin
                    axi_rsp.bresp <= DCP_RESP_SLVERR;
                end
            end else if (axi_rsp.bvalid && axi_req.bready) begin
                axi_rsp.bvalid <= 1'b0;
            end
        end
    end

    // register storage; status is read-only and a write to it is dropped
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_a_q <= DCP_A_RST;
            reg_b_q <= DCP_B_RST;
            conv_div_q <= DCP_CONV_DIV_RST;
        end else if (clk_en && aw_seen_q && w_seen_q && !axi_rsp.bvalid) begin
            if (aw_addr_q == DCP_OFS_SETUP_A) begin
                reg_a_q <= merge(reg_a_q, w_data_q, w_strb_q) & 32'h0000_ff7f;
            end else if (aw_addr_q == DCP_OFS_SETUP_B) begin
                reg_b_q <= merge(reg_b_q, w_data_q, w_strb_q) & 32'h0000_3f01;
            end else if (aw_addr_q == DCP_OFS_CONV_DIV) begin
                // zero would give a strobe on every detector tick, the same as one, so it is kept at one
                conv_div_q <= (conv_merged[15:0] == 16'h0000) ? 16'h0001 : conv_merged[15:0];
            end
        end
    end

    // read channel
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            axi_rsp.arready <= 1'b0;
            axi_rsp.rvalid <= 1'b0;
            axi_rsp.rdata <= 32'h0000_0000;
            axi_rsp.rresp <= DCP_RESP_OKAY;
        end else if (clk_en) begin
            axi_rsp.arready <= 1'b0;
            if (axi_req.arvalid && !axi_rsp.rvalid && !axi_rsp.arready) begin
                axi_rsp.arready <= 1'b1;
                axi_rsp.rvalid <= 1'b1;
                axi_rsp.rresp <= DCP_RESP_OKAY;
                if (axi_req.araddr == DCP_OFS_SETUP_A) begin
                    axi_rsp.rdata <= reg_a_q;
                end else if (axi_req.araddr == DCP_OFS_SETUP_B) begin
                    axi_rsp.rdata <= reg_b_q;
                end else if (axi_req.araddr == DCP_OFS_STATUS) begin
                    axi_rsp.rdata <= {27'h0, loop_ratio_bad_q, output_strobe_q, use_pll_clock_q, 2'(mode)};
                end else if (axi_req.araddr == DCP_OFS_CONV_DIV) begin
                    axi_rsp.rdata <= {16'h0000, conv_div_q};
                end else begin
                    axi_rsp.rdata <= 32'h0000_0000;
                    axi_rsp.rresp <= DCP_RESP_SLVERR;
                end
            end else if (axi_rsp.rvalid && axi_req.rready) begin
                axi_rsp.rvalid <= 1'b0;
            end
        end
    end

    // mode from the enable and sleep bits; mixed settings are flagged, not blocked
    always_comb begin
        if (reg_a_q[DCP_A_ENA_BIT] && !reg_b_q[DCP_B_SLEEP_BIT]) begin
            mode = DCP_MODE_PLL;
        end else if (!reg_a_q[DCP_A_ENA_BIT] && reg_b_q[DCP_B_SLEEP_BIT]) begin
            mode = DCP_MODE_BYPASS;
        end else begin
            mode = DCP_MODE_MIXED;
        end
    end

    // prescale times m, for the loop-ratio health flag
    // widen before multiplying so that 7 x 255 does not wrap
    assign loop_ratio = 11'(reg_a_q[DCP_A_P_LSB +: 3]) * 11'(reg_a_q[DCP_A_M_LSB +: 8]);
    assign conv_merged = merge({16'h0000, conv_div_q}, w_data_q, w_strb_q);

    // configuration handed to the analog loop
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q <= '0;
            use_pll_clock_q <= 1'b0;
            loop_ratio_bad_q <= 1'b0;
        end else if (clk_en) begin
            cfg_q.pll_enable <= reg_a_q[DCP_A_ENA_BIT];
            cfg_q.pll_sleep <= reg_b_q[DCP_B_SLEEP_BIT];
            cfg_q.prescale <= reg_a_q[DCP_A_P_LSB +: 3];
            cfg_q.vco_coarse <= reg_b_q[DCP_B_VCO_LSB +: 6];
            cfg_q.m_div <= reg_a_q[DCP_A_M_LSB +: 8];
            cfg_q.charge_pump_select <= reg_a_q[DCP_A_CP_LSB +: 2];
            // the clock mux follows pll enable; sleeping pll cannot feed it
            use_pll_clock_q <= reg_a_q[DCP_A_ENA_BIT] && !reg_b_q[DCP_B_SLEEP_BIT];
            // bad when out of range, or above 120 without double charge pump
            loop_ratio_bad_q <= (loop_ratio < 11'(DCP_LOOP_MIN)) || (loop_ratio > 11'(DCP_LOOP_MAX))
                || ((loop_ratio > 11'(DCP_LOOP_FILT)) && (reg_a_q[DCP_A_CP_LSB +: 2] != DCP_CP_DOUBLE));
        end
    end

    // detector-rate divider: clk stands for the converter clock; m of 0 holds the divider stopped
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            m_cnt_q <= 8'h00;
        end else if (clk_en) begin
            if (m_cnt_q + 8'h01 >= reg_a_q[DCP_A_M_LSB +: 8]) begin
                m_cnt_q <= 8'h00;
            end else begin
                m_cnt_q <= m_cnt_q + 8'h01;
            end
        end
    end

    // n-divider strobe: one pulse each conv_div detector ticks, programmed to n*interp*8/m
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            n_cnt_q <= 16'h0000;
            output_strobe_q <= 1'b0;
        end else if (clk_en) begin
            output_strobe_q <= 1'b0;
            if (mode != DCP_MODE_PLL) begin
                n_cnt_q <= 16'h0000;
                output_strobe_q <= ext_output_strobe;
            end else if (m_cnt_q == 8'h00 && reg_a_q[DCP_A_M_LSB +: 8] != 8'h00) begin
                if (n_cnt_q + 16'h0001 >= conv_div_q) begin
                    n_cnt_q <= 16'h0000;
                    output_strobe_q <= 1'b1;
                end else begin
                    n_cnt_q <= n_cnt_q + 16'h0001;
                end
            end
        end
    end
endmodule

// *** verilog/dcp_pkg.sv ***
package dcp_pkg;
    // register byte offsets (aligned words on the lite bus)
    localparam logic [7:0] DCP_OFS_SETUP_A = 8'h00;
    localparam logic [7:0] DCP_OFS_SETUP_B = 8'h04;
    localparam logic [7:0] DCP_OFS_STATUS = 8'h08;
    localparam logic [7:0] DCP_OFS_CONV_DIV = 8'h0c;
    // pll_setup_reg_a field positions
    localparam int DCP_A_ENA_BIT = 0;
    localparam int DCP_A_CP_LSB = 1;
    localparam int DCP_A_P_LSB = 4;
    localparam int DCP_A_M_LSB = 8;
    // pll_setup_reg_b field positions
    localparam int DCP_B_SLEEP_BIT = 0;
    localparam int DCP_B_VCO_LSB = 8;
    // reset values: bypass mode (pll off, asleep)
    localparam logic [31:0] DCP_A_RST = 32'h0000_0000;
    localparam logic [31:0] DCP_B_RST = 32'h0000_0001;
    localparam logic [15:0] DCP_CONV_DIV_RST = 16'h0001;
    // charge-pump encodings
    localparam logic [1:0] DCP_CP_SINGLE = 2'h1;
    localparam logic [1:0] DCP_CP_DOUBLE = 2'h3;
    // loop guidance limits
    localparam int DCP_LOOP_MIN = 24;
    localparam int DCP_LOOP_MAX = 480;
    localparam int DCP_LOOP_FILT = 120;
    // axi responses
    localparam logic [1:0] DCP_RESP_OKAY = 2'h0;
    localparam logic [1:0] DCP_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        DCP_MODE_BYPASS,
        DCP_MODE_PLL,
        DCP_MODE_MIXED
    } dcp_mode_e;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } dcp_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } dcp_axi_rsp_s;

    typedef struct packed {
        logic pll_enable;
        logic pll_sleep;
        logic [2:0] prescale;
        logic [5:0] vco_coarse;
        logic [7:0] m_div;
        logic [1:0] charge_pump_select;
    } dcp_cfg_s;
endpackage

// *** sim/dcp_strobe_src.sv ***
`timescale 1ns/1ns
// far-side strobe pin: one-cycle pulse every PERIOD converter clocks
module dcp_strobe_src #(
    parameter int PERIOD = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // strobe pin
    output logic strobe
);
    int cnt_q;
    // period is n x interpolation x 8; 16 means n=1 at 2x
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 0;
            strobe <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
            strobe <= (cnt_q == PERIOD - 1);
        end
    end
endmodule

// *** sim/dcp_clock_ctrl_props.sv ***
`timescale 1ns/1ns
module dcp_clock_ctrl_props #(
    parameter int M_WIDTH = 8
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // register bus
    input wire dcp_pkg::dcp_axi_req_s axi_req,
    input wire dcp_pkg::dcp_axi_rsp_s axi_rsp,
    // strobes and controls
    input wire logic ext_output_strobe,
    input wire dcp_pkg::dcp_cfg_s cfg_q,
    input wire logic use_pll_clock_q,
    input wire logic output_strobe_q,
    input wire logic loop_ratio_bad_q
);
    import dcp_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    logic [M_WIDTH+2:0] pm;
    logic [9:0] gap_q;
    logic seen_q;
    assign pm = cfg_q.prescale * cfg_q.m_div;
    // period judged only between two internal strobes under one m setting
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gap_q <= '0;
            seen_q <= 1'b0;
        end else if (clk_en) begin
            gap_q <= output_strobe_q ? '0 : gap_q + 10'h1;
            seen_q <= use_pll_clock_q && (seen_q || output_strobe_q) && !$changed(cfg_q.m_div);
        end
    end
    AST_USE_PLL: assert property (use_pll_clock_q == (cfg_q.pll_enable && !cfg_q.pll_sleep))
        else $error("pll select does not follow enable and sleep");
    AST_EXT_STROBE: assert property ($past(clk_en) && !use_pll_clock_q
        |-> output_strobe_q == $past(ext_output_strobe)) else $error("bypass strobe not taken from pin");
    AST_PLL_PULSE: assert property (use_pll_clock_q && output_strobe_q && cfg_q.m_div > 8'h1
        |=> !output_strobe_q || !use_pll_clock_q) else $error("internal strobe wider than one cycle");
    AST_STROBE_M: assert property (output_strobe_q && seen_q && cfg_q.m_div != 8'h0
        |-> (gap_q + 10'h1) % cfg_q.m_div == 0) else $error("strobe period not a multiple of m");
    AST_RATIO: assert property ($past(arst_n) |-> loop_ratio_bad_q == (pm < DCP_LOOP_MIN
        || pm > DCP_LOOP_MAX || (pm > DCP_LOOP_FILT && cfg_q.charge_pump_select != DCP_CP_DOUBLE)))
        else $error("loop ratio flag wrong");
    AST_W_ANSWER: assert property (axi_req.awvalid && axi_req.wvalid && clk_en |-> ##[1:4] axi_rsp.bvalid)
        else $error("write response missing");
    AST_B_DONE: assert property (axi_rsp.bvalid && axi_req.bready && clk_en |=> !axi_rsp.bvalid)
        else $error("write response not retired");
    AST_R_ANSWER: assert property (axi_req.arvalid && clk_en |-> ##[0:3] axi_rsp.rvalid)
        else $error("read data missing");
    AST_R_DONE: assert property (axi_rsp.rvalid && axi_req.rready && clk_en |=> !axi_rsp.rvalid)
        else $error("read data not retired");
    cover property (use_pll_clock_q && output_strobe_q && seen_q);
    cover property (!use_pll_clock_q && output_strobe_q);
    cover property (axi_rsp.rvalid && axi_rsp.rresp == DCP_RESP_SLVERR);
endmodule

// *** sim/dcp_clock_ctrl_tb_top.sv ***
`timescale 1ns/1ns
module dcp_clock_ctrl_tb_top;
    import dcp_pkg::*;
    logic clk, arst_n, clk_en, ext_strobe, use_pll, strobe, bad;
    dcp_axi_req_s rq;
    dcp_axi_rsp_s rs;
    dcp_cfg_s cfg;
    int miscompares, compares, cyc, t;
    logic [31:0] d, e;
    logic [1:0] r;
    logic [2:0] pt [7] = '{3'h1, 3'h3, 3'h5, 3'h5, 3'h7, 3'h6, 3'h4};
    logic [7:0] mt [7] = '{8'h08, 8'h08, 8'h20, 8'h20, 8'h40, 8'h60, 8'h1e};
    logic [1:0] ct [7] = '{2'h1, 2'h1, 2'h1, 2'h3, 2'h3, 2'h3, 2'h1};
    dcp_clock_ctrl dut_u (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .axi_req(rq), .axi_rsp(rs),
        .ext_output_strobe(ext_strobe), .cfg_q(cfg), .use_pll_clock_q(use_pll),
        .output_strobe_q(strobe), .loop_ratio_bad_q(bad));
    dcp_strobe_src #(.PERIOD(16)) src_u (.clk(clk), .arst_n(arst_n), .strobe(ext_strobe));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(string n, logic [31:0] x, logic [31:0] s);
        compares++;
        if (s !== x) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge clk);
        rq.awaddr <= a;
        rq.wdata <= v;
        rq.awvalid <= 1'b1;
        rq.wvalid <= 1'b1;
        rq.bready <= 1'b1;
        do begin
            @(posedge clk);
            if (rs.awready) rq.awvalid <= 1'b0;
            if (rs.wready) rq.wvalid <= 1'b0;
        end while (!rs.bvalid);
        r = rs.bresp;
        rq.bready <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge clk);
        rq.araddr <= a;
        rq.arvalid <= 1'b1;
        rq.rready <= 1'b1;
        do begin
            @(posedge clk);
            if (rs.arready) rq.arvalid <= 1'b0;
        end while (!rs.rvalid);
        d = rs.rdata;
        r = rs.rresp;
        rq.rready <= 1'b0;
    endtask
    // cycles between two strobe pulses
    task automatic tmeas();
        @(posedge clk);
        while (!strobe) @(posedge clk);
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (!strobe);
    endtask
    function automatic logic bad_of(int p, int m, logic [1:0] c);
        return p * m < DCP_LOOP_MIN || p * m > DCP_LOOP_MAX || (p * m > DCP_LOOP_FILT && c != DCP_CP_DOUBLE);
    endfunction
    initial begin
        clk_en = 1'b1;
        arst_n = 1'b0;
        rq = '0;
        rq.wstrb = 4'hf;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        rd(DCP_OFS_SETUP_A);
        chk("reg_a", DCP_A_RST, d);
        rd(DCP_OFS_SETUP_B);
        chk("reg_b", DCP_B_RST, d);
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            e = {16'h0, mt[i], 1'b0, pt[i], 1'b0, ct[i], 1'b0};
            wr(DCP_OFS_SETUP_A, e);
            rd(DCP_OFS_SETUP_A);
            chk("reg_a", e, d);
            chk("prescale", pt[i], cfg.prescale);
            chk("m_div", mt[i], cfg.m_div);
            chk("cp", ct[i], cfg.charge_pump_select);
            chk("ratio_bad", bad_of(pt[i], mt[i], ct[i]), bad);
        end
        $display("test fields done");
        wr(DCP_OFS_CONV_DIV, 32'h3);
        wr(DCP_OFS_SETUP_A, 32'h0000_0433);
        wr(DCP_OFS_SETUP_B, 32'h0000_2a00);
        rd(DCP_OFS_STATUS);
        chk("status", 3'h5, d[2:0]);
        chk("vco", 6'h2a, cfg.vco_coarse);
        tmeas();
        chk("pll_period", 32'h4 * 32'h3, t);
        $display("test pll done");
        wr(DCP_OFS_SETUP_B, 32'h0000_2a01);
        rd(DCP_OFS_STATUS);
        chk("status", 3'h2, d[2:0]);
        wr(DCP_OFS_SETUP_A, 32'h0000_0432);
        rd(DCP_OFS_STATUS);
        chk("status", 3'h0, d[2:0]);
        chk("ratio_bit", 1'b1, d[4]);
        tmeas();
        chk("pin_period", 32'h10, t);
        $display("test bypass done");
        rd(8'h10);
        chk("unmapped_resp", 32'(DCP_RESP_SLVERR), 32'(r));
        chk("unmapped_data", 32'h0, d);
        wr(DCP_OFS_STATUS, 32'hffff_ffff);
        chk("status_wr_resp", 32'(DCP_RESP_OKAY), 32'(r));
        rd(DCP_OFS_STATUS);
        chk("status_ro", 3'h0, d[2:0]);
        wr(DCP_OFS_CONV_DIV, 32'h0);
        rd(DCP_OFS_CONV_DIV);
        chk("conv_div", 32'h1, d);
        $display("test refusals done");
        report_and_stop();
    end
endmodule
bind dcp_clock_ctrl dcp_clock_ctrl_props #(.M_WIDTH(M_WIDTH)) props_u (.clk(clk), .arst_n(arst_n),
    .clk_en(clk_en), .axi_req(axi_req), .axi_rsp(axi_rsp), .ext_output_strobe(ext_output_strobe),
    .cfg_q(cfg_q), .use_pll_clock_q(use_pll_clock_q), .output_strobe_q(output_strobe_q),
    .loop_ratio_bad_q(loop_ratio_bad_q));
